/* core/cpmux_map.svh */
// Constants for the controller port multiplexer
`ifndef CPMUX_MAP_SVH
`define CPMUX_MAP_SVH
// ==========================================================
// Stream layout and presence pattern
`define CPMUX_GROUP_BITS 17
`define CPMUX_CONNECT_BIT 17
`define CPMUX_SIG_FIRST 13
`define CPMUX_SIG_LAST 16
`define CPMUX_PROBE_READS 8
`define CPMUX_PROBE_ALL 8'hFF
// Host shift clock half period in ns and in cycles
`define CPMUX_HALF_NS 96
`define CPMUX_MCLK_NS 8
`define CPMUX_HALF_CYC (`CPMUX_HALF_NS / `CPMUX_MCLK_NS)
`endif

/* core/cpmux_pkg.sv */
// Types shared by both ends of the controller port multiplexer
package cpmux_pkg;
    typedef enum logic {
        CPMUX_DUAL_PORT,
        CPMUX_FIVE_PLAYER
    } cpmux_setting_e;
    typedef logic [3:0] cpmux_conn_t;
    typedef enum logic [1:0] {
        CPMUX_OP_READ,
        CPMUX_OP_PROBE,
        CPMUX_OP_NONE
    } cpmux_op_e;
endpackage : cpmux_pkg

/* core/cpmux_if.sv */
// Console port lines between host and adapter
`timescale 1ns/1ps
`default_nettype none
interface cpmux_if;
    logic latch_strobe_line;
    logic shift_clock_line;
    logic group_select_bit;
    logic [1:0] data;
    modport adapter (
        input latch_strobe_line,
        input shift_clock_line,
        input group_select_bit,
        output data
    );
    modport host (
        output latch_strobe_line,
        output shift_clock_line,
        output group_select_bit,
        input data
    );
endinterface : cpmux_if
`default_nettype wire

/* core/cpmux_adapter.sv */
// Adapter end: fans console lines out to four connectors
`timescale 1ns/1ps
`default_nettype none
module cpmux_adapter (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Setting switch
    input wire cpmux_pkg::cpmux_setting_e i_setting,
    // Console side
    cpmux_if.adapter port,
    // Connector lines, index 0..3 are connectors 2..5
    output logic [3:0] o_conn_latch,
    output logic [3:0] o_conn_clock,
    input wire logic [3:0] i_conn_data,
    output logic o_conn_io
);
    import cpmux_pkg::*;
    // ==========================================================
    // Fan-out
    // Plain wires so every connector sees the same edge.
    wire five_w = (i_setting == CPMUX_FIVE_PLAYER);
    wire [3:0] active_w = five_w ? 4'hF : 4'h1;
    assign o_conn_latch = active_w & {4{port.latch_strobe_line}};
    // Each group is clocked only while selected, so connectors 4,5
    // still hold their first bit when the host swaps groups.
    wire [3:0] clk_en_w = five_w ? (port.group_select_bit ? 4'h3 : 4'hC)
                                 : 4'h1;
    assign o_conn_clock = clk_en_w & {4{port.shift_clock_line}};
    assign o_conn_io = five_w ? 1'b0 : port.group_select_bit;
    // ==========================================================
    // Data selection
    // Connector data passes unaltered, so signatures, the connect
    // flag and button levels are the peripheral's own.
    wire sel_w = port.group_select_bit;
    wire d0_w = sel_w ? i_conn_data[0] : i_conn_data[2];
    wire d1_w = sel_w ? i_conn_data[1] : i_conn_data[3];
    // Latch high forces D1 high for the presence pattern.
    wire d1_five_w = port.latch_strobe_line | d1_w;
    // No register: bits stay aligned with a direct controller.
    assign port.data = five_w ? {d1_five_w, d0_w}
                              : {1'b0, i_conn_data[0]};
    // Clock and reset are unused: the adapter keeps no state.
    wire unused_w = i_mclk ^ i_srst;
endmodule : cpmux_adapter
`default_nettype wire

/* core/cpmux_host.sv */
// Host end: reads two groups and runs the presence check
`timescale 1ns/1ps
`default_nettype none
`include "cpmux_map.svh"
module cpmux_host (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Command
    input wire cpmux_pkg::cpmux_op_e i_op,
    input wire logic i_start,
    // Results
    output logic o_busy,
    output logic o_done,
    output logic [16:0] o_grp_hi_d0,
    output logic [16:0] o_grp_hi_d1,
    output logic [16:0] o_grp_lo_d0,
    output logic [16:0] o_grp_lo_d1,
    output logic o_present,
    // Console side
    cpmux_if.host port
);
    import cpmux_pkg::*;
    typedef enum logic [2:0] {
        CPMUX_IDLE, CPMUX_LATCH, CPMUX_SHIFT, CPMUX_SWAP, CPMUX_FIN
    } cpmux_state_e;
    cpmux_state_e state_q;
    logic probe_q, grp_q, clk_q, lat_q, sel_q;
    logic [4:0] bit_q;
    logic [3:0] tim_q;
    logic [7:0] ph1_q, ph2_q;
    logic [1:0] d_s1_q, d_s2_q, d_s3_q, d_f_q;
    function automatic logic [16:0] shin(input logic [16:0] v,
                                         input logic b);
        shin = {v[15:0], b};
    endfunction : shin
    wire tick_w = (tim_q == 4'(`CPMUX_HALF_CYC - 1));
    // Three-stage sample; change counts once stages two and three agree
    wire [1:0] din_w = d_f_q;
    wire last_w = probe_q ? (bit_q == 5'(2 * `CPMUX_PROBE_READS - 1))
                          : (bit_q == 5'(`CPMUX_GROUP_BITS - 1));
    always_ff @(posedge i_mclk) begin
        d_s1_q <= port.data;
        d_s2_q <= d_s1_q;
        d_s3_q <= d_s2_q;
        if (d_s2_q == d_s3_q) begin
            d_f_q <= d_s3_q;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_q <= CPMUX_IDLE;
            {probe_q, grp_q, clk_q, lat_q, o_busy, o_done} <= 6'h00;
            sel_q <= 1'b1;
            bit_q <= 5'h00;
            tim_q <= 4'h0;
            {ph1_q, ph2_q} <= 16'h0000;
            {o_grp_hi_d0, o_grp_hi_d1} <= 34'h0;
            {o_grp_lo_d0, o_grp_lo_d1} <= 34'h0;
            o_present <= 1'b0;
        end else begin
            o_done <= 1'b0;
            tim_q <= tick_w ? 4'h0 : tim_q + 4'h1;
            unique case (state_q)
                CPMUX_IDLE: if (i_start && i_op != CPMUX_OP_NONE) begin
                    probe_q <= (i_op == CPMUX_OP_PROBE);
                    o_busy <= 1'b1;
                    grp_q <= 1'b0;
                    sel_q <= 1'b1;
                    lat_q <= 1'b1;
                    bit_q <= 5'h00;
                    tim_q <= 4'h0;
                    state_q <= CPMUX_LATCH;
                end
                CPMUX_LATCH: if (tick_w) begin
                    lat_q <= probe_q; // Probe keeps latch high
                    state_q <= CPMUX_SHIFT;
                end
                CPMUX_SHIFT: if (tick_w) begin
                    clk_q <= ~clk_q;
                    if (!clk_q) begin
                        // Sample on the rising shift edge
                        if (probe_q) begin
                            if (bit_q < 5'(`CPMUX_PROBE_READS)) begin
                                ph1_q <= {ph1_q[6:0], din_w[1]};
                            end else begin
                                ph2_q <= {ph2_q[6:0], din_w[1]};
                            end
                            if (bit_q == 5'(`CPMUX_PROBE_READS - 1)) begin
                                lat_q <= 1'b0;
                            end
                        end else if (!grp_q) begin
                            o_grp_hi_d0 <= shin(o_grp_hi_d0, din_w[0]);
                            o_grp_hi_d1 <= shin(o_grp_hi_d1, din_w[1]);
                        end else begin
                            o_grp_lo_d0 <= shin(o_grp_lo_d0, din_w[0]);
                            o_grp_lo_d1 <= shin(o_grp_lo_d1, din_w[1]);
                        end
                        bit_q <= bit_q + 5'h01;
                        if (last_w) begin
                            state_q <= (probe_q || grp_q) ? CPMUX_FIN
                                                          : CPMUX_SWAP;
                        end
                    end
                end
                CPMUX_SWAP: if (tick_w) begin
                    // Group 2,3 first: select falls fast, rises slowly
                    sel_q <= 1'b0;
                    // Clock drops in the same cycle as select so the newly gated group sees no edge
                    clk_q <= 1'b0;
                    grp_q <= 1'b1;
                    bit_q <= 5'h00;
                    state_q <= CPMUX_SHIFT;
                end
                CPMUX_FIN: if (tick_w) begin
                    sel_q <= 1'b1;
                    clk_q <= 1'b0;
                    lat_q <= 1'b0;
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    if (probe_q) begin
                        o_present <= (ph1_q == `CPMUX_PROBE_ALL) &&
                                     (ph2_q != `CPMUX_PROBE_ALL);
                    end
                    state_q <= CPMUX_IDLE;
                end
                default: state_q <= CPMUX_IDLE;
            endcase
        end
    end
    assign port.latch_strobe_line = lat_q;
    assign port.shift_clock_line = clk_q;
    assign port.group_select_bit = sel_q;
endmodule : cpmux_host
`default_nettype wire

/* dv/cpmux_checker.sv */
// Assertions on the console port lines of the multiplexer
`timescale 1ns/1ps
`default_nettype none
module cpmux_checker (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Adapter side
    input wire cpmux_pkg::cpmux_setting_e i_setting,
    input wire logic [3:0] i_conn_data,
    input wire logic [3:0] i_conn_latch,
    input wire logic [3:0] i_conn_clock,
    input wire logic i_conn_io,
    // Console lines
    input wire logic latch_strobe_line,
    input wire logic shift_clock_line,
    input wire logic group_select_bit,
    input wire logic [1:0] data
);
    import cpmux_pkg::*;
    // =====================================================
    // Properties
    wire five = i_setting == CPMUX_FIVE_PLAYER;
    wire lat = latch_strobe_line;
    wire sel = group_select_bit;
    wire sck = shift_clock_line;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    property p_hi_grp;
        five && sel && !lat |-> data == i_conn_data[1:0];
    endproperty
    property p_lo_grp;
        five && !sel && !lat |-> data == i_conn_data[3:2];
    endproperty
    property p_probe;
        five && lat |-> data[1];
    endproperty
    property p_dual_d0;
        !five |-> data[0] == i_conn_data[0];
    endproperty
    property p_dual_d1;
        !five |-> !data[1];
    endproperty
    // Select rises slowly on real wiring, so it must not stay low long
    property p_sel_back;
        $fell(sel) |-> ##[1:600] sel;
    endproperty
    property p_latch_len;
        $rose(lat) |-> lat[*8];
    endproperty
    property p_clk_half;
        $rose(sck) |-> sck[*8];
    endproperty
    property p_sel_lat;
        !sel |-> !lat;
    endproperty
    property p_conn_clk;
        i_conn_clock == (!five ? {3'b000, sck}
                         : sel ? {2'b00, sck, sck} : {sck, sck, 2'b00});
    endproperty
    property p_conn_latch;
        i_conn_latch == (five ? {4{lat}} : {3'b000, lat});
    endproperty
    property p_conn_io;
        i_conn_io == (!five && sel);
    endproperty
    a_hi_grp: assert property (p_hi_grp) else $error("group high wrong");
    a_lo_grp: assert property (p_lo_grp) else $error("group low wrong");
    a_probe: assert property (p_probe) else $error("probe low");
    a_dual_d0: assert property (p_dual_d0) else $error("dual d0");
    a_dual_d1: assert property (p_dual_d1) else $error("dual d1");
    a_sel_back: assert property (p_sel_back) else $error("sel low");
    a_latch_len: assert property (p_latch_len) else $error("latch");
    a_clk_half: assert property (p_clk_half) else $error("clock");
    a_sel_lat: assert property (p_sel_lat) else $error("order");
    a_conn_clk: assert property (p_conn_clk) else $error("conn clk");
    a_conn_latch: assert property (p_conn_latch) else $error("latch");
    a_conn_io: assert property (p_conn_io) else $error("io");
    c_lo: cover property (five && !sel);
    c_probe: cover property (five && lat && sck);
    c_dual: cover property (!five && $rose(sck));
    c_swap: cover property (five && $fell(sel));
endmodule : cpmux_checker
`default_nettype wire

/* dv/test_cpmux.sv */
// Testbench joining host and adapter ends of the multiplexer
`timescale 1ns/1ps
`default_nettype none
module test_cpmux;
    import cpmux_pkg::*;
    logic i_mclk, i_srst, i_start, o_busy, o_done, o_present, o_conn_io;
    logic five;
    cpmux_setting_e i_setting;
    cpmux_op_e i_op;
    logic [3:0] o_conn_latch, o_conn_clock, i_conn_data, ck_q;
    logic [16:0] h0, h1, l0, l1;
    logic [16:0] st [4];
    logic [31:0] lfsr;
    int idx [4] = '{17, 17, 17, 17};
    int n_mismatch = 0;
    int compares = 0;
    cpmux_if bus ();
    cpmux_adapter u_cpmux_adapter (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_setting(i_setting), .port(bus), .o_conn_latch(o_conn_latch),
        .o_conn_clock(o_conn_clock), .i_conn_data(i_conn_data),
        .o_conn_io(o_conn_io));
    cpmux_host u_cpmux_host (.i_mclk(i_mclk), .i_srst(i_srst), .i_op(i_op),
        .i_start(i_start), .o_busy(o_busy), .o_done(o_done),
        .o_grp_hi_d0(h0), .o_grp_hi_d1(h1), .o_grp_lo_d0(l0),
        .o_grp_lo_d1(l1), .o_present(o_present), .port(bus));
    cpmux_checker u_cpmux_checker (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_setting(i_setting), .i_conn_data(i_conn_data),
        .i_conn_latch(o_conn_latch), .i_conn_clock(o_conn_clock),
        .i_conn_io(o_conn_io),
        .latch_strobe_line(bus.latch_strobe_line),
        .shift_clock_line(bus.shift_clock_line),
        .group_select_bit(bus.group_select_bit), .data(bus.data));
    // =====================================================
    // Connectors: shift on the falling clock so the rising sample is settled
    always @(negedge i_mclk) begin
        for (int k = 0; k < 4; k++) begin
            if (o_conn_latch[k]) idx[k] = 0;
            else if (ck_q[k] && !o_conn_clock[k]) idx[k]++;
            i_conn_data[k] = idx[k] < 17 ? st[k][16 - idx[k]] : 1'b0;
        end
        ck_q = o_conn_clock;
    end
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task automatic chk(input logic [16:0] seen, exp, input string nm);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic results;
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // Start is held two cycles: the second one lands while busy
    task automatic run(input cpmux_op_e op);
        int n;
        n = 0;
        i_op = op;
        i_start = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_start = 1'b0;
        while (o_done !== 1'b1 && n < 2000) begin
            @(negedge i_mclk);
            n++;
        end
        if (n == 2000) begin
            n_mismatch++;
            results();
        end
        chk(o_busy, 17'h0, "busy");
    endtask : run
    // =====================================================
    // Main sequence
    initial begin
        i_srst = 1'b1;
        i_start = 1'b0;
        i_op = CPMUX_OP_NONE;
        i_setting = CPMUX_FIVE_PLAYER;
        i_conn_data = 4'h0;
        ck_q = 4'h0;
        lfsr = 32'h6882A04F;
        repeat (12) @(negedge i_mclk);
        i_srst = 1'b0;
        for (int t = 0; t < 6; t++) begin
            i_setting = t < 4 ? CPMUX_FIVE_PLAYER : CPMUX_DUAL_PORT;
            five = t < 4;
            for (int k = 0; k < 4; k++) begin
                lfsr = nx(lfsr);
                st[k] = t == 1 ? 17'h0 : t == 2 ? lfsr[16:0]
                    : {lfsr[11:0], 4'h0, 1'b1};
            end
            run(CPMUX_OP_READ);
            chk(h0, st[0], "hi_d0");
            chk(h1, five ? st[1] : 17'h0, "hi_d1");
            chk(l0, five ? st[2] : 17'h0, "lo_d0");
            chk(l1, five ? st[3] : 17'h0, "lo_d1");
            run(CPMUX_OP_PROBE);
            chk(o_present, five && st[1][16:9] != 8'hFF, "present");
        end
        results();
    end
endmodule : test_cpmux
`default_nettype wire
